// *** design/irq_ctrl.sv ***
// interrupt controller: latching, masking, priority, vectoring and wake-up
`timescale 1ns/1ps
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int EXT_WIDTH = NUM_EXT_PINS
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // external pin groups, asynchronous
    input  wire logic [EXT_WIDTH-1:0] ext0_pins,
    input  wire logic [EXT_WIDTH-1:0] ext1_pins,
    input  wire logic [EXT_WIDTH-1:0] ext0_pin_en,
    input  wire logic [EXT_WIDTH-1:0] ext1_pin_en,
    input  wire sens_t                ext0_sens,
    input  wire sens_t                ext1_sens,
    // peripheral requests
    input  wire periph_req_t          css_req,
    input  wire periph_req_t          spi_req,
    input  wire periph_req_t          tima_req,
    input  wire periph_req_t          timb_req,
    input  wire periph_req_t          i2c_req,
    // core sequencer
    input  wire core_req_t            core,
    input  wire logic                 instr_end,
    // to the core
    output logic                      irq_pending,
    output logic [15:0]               vector_addr,
    output logic                      vector_valid,
    output logic                      reset_vector,
    output logic                      global_mask,
    output logic                      wake,
    output logic [NUM_SRC-1:0]        pending
);

    typedef struct packed {
        state_t             state;
        logic               mask;
        logic               boot;
        logic               trap_pend;
        logic [NUM_SRC-1:0] plat;
        logic [15:0]        vaddr;
        logic               vvalid;
        logic               rvec;
        logic               irq;
        logic               wake;
        logic [3:0]         sel;
        logic               sel_trap;
        logic               sel_reset;
        logic [EXT_WIDTH-1:0] s0a, s0b, s1a, s1b;
    } ctrl_state_t;

    ctrl_state_t r;
    ctrl_state_t next_r;

    logic               ext0_req;
    logic               ext1_req;
    logic [NUM_SRC-1:0] req_vec;
    logic [NUM_SRC-1:0] ready_vec;
    logic [3:0]         top_idx;
    logic               top_any;
    logic               clr_ext0;
    logic               clr_ext1;

    // lowest index wins
    function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : first_set

    // vector n sits two bytes below vector n-1
    function automatic logic [15:0] vec_of(input logic [3:0] n);
        return VEC_BASE - {11'h0, n, 1'b0};
    endfunction : vec_of

    // latch update for one peripheral source: set wins over clear
    function automatic logic periph_next(input logic cur, input periph_req_t p);
        logic nx;
        nx = cur;
        if (p.clear_write || p.clear_seq) begin
            nx = 1'b0;
        end
        if (p.flag) begin
            nx = 1'b1;
        end
        return nx;
    endfunction : periph_next

    ext_group_detect #(.WIDTH(EXT_WIDTH)) u_ext0 (
        .clk        (clk),
        .srst       (srst),
        .pins       (r.s0b),
        .pin_irq_en (ext0_pin_en),
        .sens       (ext0_sens),
        .clear      (clr_ext0),
        .req        (ext0_req)
    );

    ext_group_detect #(.WIDTH(EXT_WIDTH)) u_ext1 (
        .clk        (clk),
        .srst       (srst),
        .pins       (r.s1b),
        .pin_irq_en (ext1_pin_en),
        .sens       (ext1_sens),
        .clear      (clr_ext1),
        .req        (ext1_req)
    );

    // the latch of a source clears when its vector is handed to the core
    assign clr_ext0 = core.ack && r.vvalid && !r.sel_trap && !r.sel_reset && r.sel == SRC_EXT0;
    assign clr_ext1 = core.ack && r.vvalid && !r.sel_trap && !r.sel_reset && r.sel == SRC_EXT1;

    always_comb begin
        req_vec           = '0;
        req_vec[SRC_EXT0] = ext0_req;
        req_vec[SRC_EXT1] = ext1_req;
        // enable gates forwarding only; the latch itself keeps pending
        req_vec[SRC_CSS]  = r.plat[SRC_CSS] & css_req.enable;
        req_vec[SRC_SPI]  = r.plat[SRC_SPI] & spi_req.enable;
        req_vec[SRC_TIMA] = r.plat[SRC_TIMA] & tima_req.enable;
        req_vec[SRC_TIMB] = r.plat[SRC_TIMB] & timb_req.enable;
        req_vec[SRC_I2C]  = r.plat[SRC_I2C] & i2c_req.enable;
        req_vec           = req_vec & USED_MASK;
        ready_vec         = req_vec & {NUM_SRC{~r.mask}};
        top_idx           = first_set(ready_vec);
        top_any           = |ready_vec;
    end

    always_comb begin
        next_r = r;
        next_r.s0a = ext0_pins;
        next_r.s0b = r.s0a;
        next_r.s1a = ext1_pins;
        next_r.s1b = r.s1a;
        next_r.boot = 1'b0;

        next_r.plat[SRC_CSS]  = periph_next(r.plat[SRC_CSS], css_req);
        next_r.plat[SRC_SPI]  = periph_next(r.plat[SRC_SPI], spi_req);
        next_r.plat[SRC_TIMA] = periph_next(r.plat[SRC_TIMA], tima_req);
        next_r.plat[SRC_TIMB] = periph_next(r.plat[SRC_TIMB], timb_req);
        next_r.plat[SRC_I2C]  = periph_next(r.plat[SRC_I2C], i2c_req);

        if (core.trap) begin
            next_r.trap_pend = 1'b1;
        end

        // software mask instructions
        if (core.rim) begin
            next_r.mask = 1'b0;
        end else if (core.sim) begin
            next_r.mask = 1'b1;
        end
        if (core.interrupt_return_instruction) begin
            next_r.mask = 1'b0;
        end

        next_r.wake = 1'b0;
        unique case (r.state)
            ST_RUN: begin
                if (core.enter_wait) begin
                    next_r.mask  = 1'b0;
                    next_r.state = ST_WAIT;
                end else if (core.enter_halt) begin
                    next_r.mask  = 1'b0;
                    next_r.state = ST_HALT;
                end else if (instr_end && (r.boot || r.trap_pend || top_any)) begin
                    next_r.sel_reset = r.boot;
                    next_r.sel_trap  = !r.boot && r.trap_pend;
                    next_r.sel       = top_idx;
                    // reset, then trap, then numbered sources
                    if (r.boot) begin
                        next_r.vaddr = VEC_RESET;
                    end else if (r.trap_pend) begin
                        next_r.vaddr = VEC_TRAP;
                    end else begin
                        next_r.vaddr = vec_of(top_idx);
                    end
                    next_r.rvec   = r.boot;
                    next_r.vvalid = 1'b1;
                    next_r.irq    = 1'b1;
                    next_r.state  = ST_SERV;
                end
            end
            ST_SERV: begin
                if (core.ack && r.vvalid) begin
                    next_r.irq = 1'b0;
                    next_r.mask = 1'b1;
                    if (r.sel_trap) begin
                        next_r.trap_pend = core.trap;
                    end else if (!r.sel_reset && r.sel != SRC_EXT0 && r.sel != SRC_EXT1) begin
                        next_r.plat[r.sel] = 1'b0;
                    end
                end
                // address held until the core has fetched the vector
                if (core.fetch_done) begin
                    next_r.vvalid = 1'b0;
                    next_r.rvec   = 1'b0;
                    next_r.state  = ST_RUN;
                end
            end
            ST_WAIT: begin
                // any enabled source, including the trap, ends stop-cpu mode
                if (|req_vec || r.trap_pend) begin
                    next_r.wake  = 1'b1;
                    next_r.state = ST_RUN;
                end
            end
            ST_HALT: begin
                // the main clock is off in halt, so only pin groups can wake
                if (|(req_vec & HALT_WAKE_MASK)) begin
                    next_r.wake  = 1'b1;
                    next_r.state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r           <= '0;
            r.state     <= ST_RUN;
            r.mask      <= MASK_RESET_VAL;
            r.boot      <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign irq_pending  = r.irq;
    assign vector_addr  = r.vaddr;
    assign vector_valid = r.vvalid;
    assign reset_vector = r.rvec;
    assign global_mask  = r.mask;
    assign wake         = r.wake;
    assign pending      = r.plat;

endmodule : irq_ctrl

// *** design/irq_ctrl_pkg.sv ***
// package: constants and carriers for the interrupt controller
package irq_ctrl_pkg;

    localparam int          NUM_EXT_PINS   = 8;
    localparam int          NUM_SRC        = 14;
    localparam logic [15:0] VEC_RESET      = 16'hfffe;
    localparam logic [15:0] VEC_TRAP       = 16'hfffc;
    localparam logic [15:0] VEC_BASE       = 16'hfffa;
    localparam logic [3:0]  SRC_EXT0       = 4'h0;
    localparam logic [3:0]  SRC_EXT1       = 4'h1;
    localparam logic [3:0]  SRC_CSS        = 4'h2;
    localparam logic [3:0]  SRC_SPI        = 4'h3;
    localparam logic [3:0]  SRC_TIMA       = 4'h4;
    localparam logic [3:0]  SRC_TIMB       = 4'h6;
    localparam logic [3:0]  SRC_I2C        = 4'hb;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h0003;
    localparam logic [13:0] USED_MASK      = 14'h085f;
    localparam logic        MASK_RESET_VAL = 1'b1;

    typedef enum logic [1:0] {
        SENS_FALL_LOW = 2'h0,
        SENS_RISE     = 2'h1,
        SENS_FALL     = 2'h2,
        SENS_BOTH     = 2'h3
    } sens_t;

    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_SERV = 4'h2,
        ST_WAIT = 4'h4,
        ST_HALT = 4'h8
    } state_t;

    typedef struct packed {
        logic       flag;
        logic       enable;
        logic       clear_write;
        logic       clear_seq;
    } periph_req_t;

    typedef struct packed {
        logic       trap;
        logic       interrupt_return_instruction;
        logic       ack;
        logic       fetch_done;
        logic       enter_wait;
        logic       enter_halt;
        logic       rim;
        logic       sim;
    } core_req_t;

endpackage : irq_ctrl_pkg

// *** design/ext_group_detect.sv ***
// one external request group: nand combine, sensitivity detection, request latch
`timescale 1ns/1ps
module ext_group_detect
    import irq_ctrl_pkg::*;
#(
    parameter int WIDTH = NUM_EXT_PINS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // pins, already synchronised
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic [WIDTH-1:0] pin_irq_en,
    input  wire sens_t            sens,
    // request
    input  wire logic             clear,
    output logic                  req
);
    typedef struct packed {
        logic prev;
        logic latch;
    } grp_state_t;

    grp_state_t r;
    grp_state_t next_r;
    logic       combined;
    logic       event_hit;

    always_comb begin
        // a low enabled pin masks the whole group, even for rising edges
        combined  = ~(&(pins | ~pin_irq_en));
        event_hit = 1'b0;
        unique case (sens)
            SENS_FALL_LOW: event_hit = ~combined;
            SENS_RISE:     event_hit = combined & ~r.prev;
            SENS_FALL:     event_hit = ~combined & r.prev;
            SENS_BOTH:     event_hit = combined ^ r.prev;
        endcase
        next_r      = r;
        next_r.prev = combined;
        // set wins over the service clear; level mode follows the pin
        if (sens == SENS_FALL_LOW) begin
            next_r.latch = event_hit;
        end else if (event_hit) begin
            next_r.latch = 1'b1;
        end else if (clear) begin
            next_r.latch = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign req = r.latch;
endmodule : ext_group_detect

// *** tb/irq_ctrl_monitor.sv ***
// assertion checker for the interrupt controller ports
`timescale 1ns/1ps
module irq_ctrl_monitor
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic               clk,
    input wire logic               srst,
    // core side
    input wire core_req_t          core,
    input wire logic               instr_end,
    input wire logic               irq_pending,
    input wire logic [15:0]        vector_addr,
    input wire logic               vector_valid,
    input wire logic               reset_vector,
    input wire logic               global_mask,
    input wire logic [NUM_SRC-1:0] pending
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_mask_after_reset: assert property ($fell(srst) |-> global_mask)
        else $error("mask clear after reset");
    a_masked_not_taken: assert property (
        $rose(vector_valid) && !reset_vector && vector_addr != VEC_TRAP |-> !$past(global_mask))
        else $error("maskable source taken while masked");
    a_vector_map: assert property (
        vector_valid && !reset_vector && vector_addr != VEC_TRAP
        |-> vector_addr inside {16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffee, 16'hffe4})
        else $error("vector outside the used set");
    a_reset_vector: assert property (reset_vector && vector_valid |-> vector_addr == VEC_RESET)
        else $error("reset vector address wrong");
    a_vector_hold: assert property (vector_valid && !core.fetch_done |=> vector_valid && $stable(vector_addr))
        else $error("vector moved before fetch");
    a_ack_masks: assert property (irq_pending && core.ack |=> global_mask && !irq_pending)
        else $error("ack did not set mask");
    a_return_unmasks: assert property (core.interrupt_return_instruction && !irq_pending |=> !global_mask)
        else $error("return left mask set");
    a_sleep_unmasks: assert property (
        (core.enter_wait || core.enter_halt) && !vector_valid && !irq_pending |=> !global_mask)
        else $error("sleep entry left mask set");
    a_unused_quiet: assert property ((pending & ~USED_MASK) == 14'h0)
        else $error("unused source pending");
    a_trap_taken: assert property (
        core.trap && instr_end && !vector_valid |-> ##[1:3] (vector_valid && vector_addr == VEC_TRAP))
        else $error("trap not taken");
endmodule : irq_ctrl_monitor

bind irq_ctrl irq_ctrl_monitor monitor (.clk(clk), .srst(srst), .core(core), .instr_end(instr_end),
    .irq_pending(irq_pending), .vector_addr(vector_addr), .vector_valid(vector_valid),
    .reset_vector(reset_vector), .global_mask(global_mask), .pending(pending));

// *** tb/core_seq_model.sv ***
// behavioural core sequencer: acknowledges and fetches vectors
`timescale 1ns/1ps
module core_seq_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // from the controller, and stall from the bench
    input  wire logic        irq_pending,
    input  wire logic [15:0] vector_addr,
    input  wire logic        stall,
    // to the controller and bench
    output logic             ack,
    output logic             fetch_done,
    output logic [15:0]      taken_vec,
    output int               taken_cnt
);
    initial begin
        ack = 1'b0;
        fetch_done = 1'b0;
        taken_vec = 16'h0;
        taken_cnt = 0;
    end
    // stall holds off the acknowledge and fetch, so the vector must hold meanwhile
    always @(negedge clk) begin
        ack <= 1'b0;
        fetch_done <= 1'b0;
        if (!srst && irq_pending && !ack && !stall) begin
            ack <= 1'b1;
            fetch_done <= 1'b1;
            taken_vec <= vector_addr;
            taken_cnt <= taken_cnt + 1;
        end
    end
endmodule : core_seq_model

// *** tb/irq_ctrl_tb_top.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_tb_top
    import irq_ctrl_pkg::*;
;
    localparam logic [7:0] C_TRAP = 8'h80, C_INTERRUPT_RETURN_INSTRUCTION = 8'h40, C_WAIT = 8'h08, C_HALT = 8'h04, C_SIM = 8'h01;
    logic        clk, srst, instr_end, stall, ack, fdone;
    int          wake_cnt = 0;
    logic        irq_pending, vector_valid, reset_vector, global_mask, wake;
    logic [7:0]  ext0_pins, ext1_pins, ext0_pin_en, ext1_pin_en;
    sens_t       ext0_sens, ext1_sens;
    periph_req_t per [5];
    core_req_t   cmd, core_in;
    logic [15:0] vector_addr, taken_vec;
    logic [13:0] pending;
    int          taken_cnt, mismatches, compares;

    always_comb begin
        core_in = cmd;
        core_in.ack = ack;
        core_in.fetch_done = fdone;
    end
    always @(posedge clk) begin
        // counted here only, so the wake pulse has a single driver
        if (wake === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    irq_ctrl #(.EXT_WIDTH(8)) dut (.clk, .srst, .ext0_pins, .ext1_pins, .ext0_pin_en, .ext1_pin_en,
        .ext0_sens, .ext1_sens, .css_req(per[0]), .spi_req(per[1]), .tima_req(per[2]), .timb_req(per[3]),
        .i2c_req(per[4]), .core(core_in), .instr_end, .irq_pending, .vector_addr, .vector_valid,
        .reset_vector, .global_mask, .wake, .pending);
    core_seq_model core_model (.clk, .srst, .irq_pending, .vector_addr, .stall, .ack, .fetch_done(fdone),
        .taken_vec, .taken_cnt);

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic cpu(input logic [7:0] v);
        cmd = core_req_t'(v);
        tick(1);
        cmd = '0;
        tick(1);
    endtask : cpu
    task automatic flag(input int i, input logic en);
        per[i].flag = 1'b1;
        per[i].enable = en;
        tick(1);
        per[i].flag = 1'b0;
        tick(1);
    endtask : flag
    task automatic clr(input int i, input logic seq);
        per[i].clear_seq = seq;
        per[i].clear_write = !seq;
        tick(1);
        per[i].clear_seq = 1'b0;
        per[i].clear_write = 1'b0;
        tick(1);
    endtask : clr
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            seen = seen | irq_pending | wake;
        end
        check("no request", 16'h0, 16'(seen));
    endtask : quiet
    // bounded wait so a lost request ends the run instead of hanging it
    task automatic take(input logic [15:0] exp, input logic ret);
        int n0;
        n0 = taken_cnt;
        for (int k = 0; k < 300 && taken_cnt == n0; k++) begin
            tick(1);
        end
        if (taken_cnt == n0) begin
            mismatches++;
            $display("[FAIL] vector expected %h seen none", exp);
            wrap_up();
        end
        check("vector", exp, taken_vec);
        tick(1);
        check("mask in service", 16'h1, 16'(global_mask));
        if (ret) begin
            cpu(C_INTERRUPT_RETURN_INSTRUCTION);
            check("mask after return", 16'h0, 16'(global_mask));
        end
    endtask : take

    task automatic t_boot();
        check("mask at reset", 16'h1, 16'(global_mask));
        take(VEC_RESET, 1'b1);
        $display("boot test done");
    endtask : t_boot
    task automatic t_periph();
        logic [15:0] vec [5] = '{16'hfff6, 16'hfff4, 16'hfff2, 16'hffee, 16'hffe4};
        for (int i = 0; i < 5; i++) begin
            flag(i, 1'b1);
            take(vec[i], 1'b1);
            check("pending", 16'h0, 16'(pending));
        end
        $display("peripheral test done");
    endtask : t_periph
    task automatic t_mask();
        cpu(C_SIM);
        flag(4, 1'b1);
        flag(0, 1'b1);
        quiet(8);
        check("pending", 16'h0804, 16'(pending));
        stall = 1'b1;
        cpu(C_TRAP);
        tick(4);
        check("held vector", 16'hfffc, vector_addr);
        stall = 1'b0;
        take(VEC_TRAP, 1'b1);
        take(16'hfff6, 1'b0);
        quiet(8);
        check("pending", 16'h0800, 16'(pending));
        cpu(C_INTERRUPT_RETURN_INSTRUCTION);
        take(16'hffe4, 1'b1);
        $display("mask test done");
    endtask : t_mask
    task automatic t_clear();
        flag(1, 1'b0);
        check("pending", 16'h0008, 16'(pending));
        clr(1, 1'b0);
        check("pending", 16'h0, 16'(pending));
        flag(1, 1'b0);
        clr(1, 1'b1);
        check("pending", 16'h0, 16'(pending));
        per[1].enable = 1'b1;
        quiet(8);
        instr_end = 1'b0;
        flag(1, 1'b1);
        quiet(6);
        instr_end = 1'b1;
        take(16'hfff4, 1'b1);
        $display("clear test done");
    endtask : t_clear
    task automatic t_ext();
        ext0_pin_en = 8'h03;
        ext0_pins = 8'hfd;
        take(16'hfffa, 1'b1);
        ext0_pins = 8'hfc;
        tick(4);
        ext0_pins = 8'hfd;
        quiet(8);
        ext0_pins = 8'hff;
        ext1_sens = SENS_FALL;
        ext1_pin_en = 8'h80;
        ext1_pins = 8'h7f;
        quiet(8);
        ext1_pins = 8'hff;
        take(16'hfff8, 1'b1);
        $display("external test done");
    endtask : t_ext
    task automatic t_wake();
        int w0;
        cpu(C_SIM);
        cpu(C_HALT);
        check("mask in halt", 16'h0, 16'(global_mask));
        flag(1, 1'b1);
        quiet(8);
        w0 = wake_cnt;
        ext0_pins = 8'hfe;
        take(16'hfffa, 1'b1);
        check("wake", 16'h1, 16'(wake_cnt - w0));
        take(16'hfff4, 1'b1);
        ext0_pins = 8'hff;
        cpu(C_WAIT);
        check("mask in wait", 16'h0, 16'(global_mask));
        w0 = wake_cnt;
        flag(0, 1'b1);
        take(16'hfff6, 1'b1);
        check("wake", 16'h1, 16'(wake_cnt - w0));
        $display("wake test done");
    endtask : t_wake

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {srst, instr_end, stall, cmd} = {3'b110, 8'h00};
        {ext0_pins, ext1_pins, ext0_pin_en, ext1_pin_en} = 32'hffff0000;
        ext0_sens = SENS_RISE;
        ext1_sens = SENS_BOTH;
        foreach (per[i]) per[i] = '0;
        tick(8);
        srst = 1'b0;
        t_boot();
        t_periph();
        t_mask();
        t_clear();
        t_ext();
        t_wake();
        wrap_up();
    end
endmodule : irq_ctrl_tb_top
